// ==== include/dcp_params.svh ====
// Constants for the DMA context program control block.
// Assumes a 32-bit register port with word-aligned byte addresses.
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// Context numbering: 0 async receive, 1..4 iso transmit, 5..8 iso receive
`define DCP_NCTX 9
`define DCP_NTX 4
`define DCP_NRX 4
`define DCP_TX0 4'h1
`define DCP_RX0 4'h5

// Register address decode
`define DCP_CTX_HI 6
`define DCP_CTX_LO 3
`define DCP_SEL_BIT 2
`define DCP_TOP_BIT 7

// Shared control fields; speed is used only by non-transmit contexts
`define DCP_RUN 15
`define DCP_WAKE 12
`define DCP_DEAD 11
`define DCP_ACT 10
`define DCP_SPD_HI 7
`define DCP_SPD_LO 5
`define DCP_CODE_HI 4
`define DCP_CODE_LO 0

// Transmit control fields
`define DCP_TX_GATE 31
`define DCP_TX_TIME_HI 30
`define DCP_TX_TIME_LO 16

// Receive control fields
`define DCP_RX_FILL 31
`define DCP_RX_KEEP 30
`define DCP_RX_GATE 29
`define DCP_RX_MANY 28
`define DCP_RX_SPLIT 27

// Program pointer fields
`define DCP_ADDR_HI 31
`define DCP_ADDR_LO 4
`define DCP_CNT_HI 3
`define DCP_CNT_LO 0
`define DCP_CNT_DONE 4'h0

`endif

// ==== include/dcp_pkg.sv ====
// Types for the DMA context program control block.
// Assumes dcp_params.svh is on the include path.
`include "dcp_params.svh"

package dcp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_GATE = 3'b001,
		ST_LOAD = 3'b010,
		ST_BUSY = 3'b011,
		ST_SLEEP = 3'b100,
		ST_HALT = 3'b101
	} dcp_state_t;

	typedef enum logic [1:0] {
		EV_NONE = 2'b00,
		EV_DONE = 2'b01,
		EV_ERR = 2'b10,
		EV_WAIT = 2'b11
	} dcp_evt_t;

	typedef struct packed {
		dcp_state_t st;
		logic active;
		logic dead;
		logic load_req;
		logic wake_ack;
	} dcp_eng_t;

	typedef struct packed {
		logic [`DCP_NCTX-1:0] run;
		logic [`DCP_NCTX-1:0] wake;
		logic [`DCP_NCTX-1:0] gate_en;
		logic [`DCP_NCTX-1:0][4:0] code;
		logic [`DCP_NCTX-1:0][27:0] addr;
		logic [`DCP_NCTX-1:0][3:0] cnt;
		logic [`DCP_NCTX-1:0][2:0] spd;
		logic [`DCP_NTX-1:0][14:0] tx_time;
		logic [`DCP_NRX-1:0] fill;
		logic [`DCP_NRX-1:0] keep;
		logic [`DCP_NRX-1:0] many;
		logic [`DCP_NRX-1:0] split;
		logic [31:0] rd_data;
		logic launch_valid;
		logic [3:0] launch_ctx;
		logic [27:0] launch_addr;
		logic [3:0] launch_cnt;
		logic [`DCP_NRX-1:0] rx_accept;
	} dcp_top_t;
endpackage

// ==== design/dcp_ctx_engine.sv ====
// Flag sequencer for one context program controller.
// Assumes all inputs are synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none

module dcp_ctx_engine
	import dcp_pkg::*;
(
	input wire logic mclk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic run, // Run flag
	input wire logic wake, // Wake flag
	input wire logic gate_en, // Start time gate armed
	input wire logic gate_hit, // Cycle timer at start time
	input wire logic grant, // Loader took the request
	input wire logic evt_done, // Program completed
	input wire logic evt_err, // Program failed
	input wire logic evt_wait, // Next program not ready
	output logic active, // Processing
	output logic dead, // Stopped by error
	output logic load_req, // Wants a program fetch
	output logic wake_ack // Wake consumed, pulse
);
	dcp_eng_t q;
	dcp_eng_t next_q;

	function automatic dcp_eng_t to_load(input dcp_eng_t s);
		dcp_eng_t r;
		r = s;
		r.st = ST_LOAD;
		r.active = 1'b1;
		r.load_req = 1'b1;
		return r;
	endfunction

	always_comb begin
		next_q = q;
		next_q.wake_ack = 1'b0;
		if (!run) begin
			next_q.st = ST_IDLE;
			next_q.active = 1'b0;
			next_q.dead = 1'b0;
			next_q.load_req = 1'b0;
		end else begin
			unique case (q.st)
				ST_IDLE: begin
					if (gate_en) begin
						next_q.st = ST_GATE;
					end else begin
						next_q = to_load(q);
					end
				end
				ST_GATE: begin
					if (gate_hit) begin
						next_q = to_load(q);
					end
				end
				ST_LOAD: begin
					if (grant) begin
						next_q.st = ST_BUSY;
						next_q.load_req = 1'b0;
					end
				end
				ST_BUSY: begin
					if (evt_err) begin
						next_q.st = ST_HALT;
						next_q.dead = 1'b1;
						next_q.active = 1'b0;
					end else if (evt_done || evt_wait) begin
						next_q.st = ST_SLEEP;
						next_q.active = 1'b0;
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						next_q = to_load(q);
						next_q.wake_ack = 1'b1;
					end
				end
				ST_HALT: begin
					next_q.dead = 1'b1;
				end
				default: begin
					next_q.st = ST_IDLE;
					next_q.active = 1'b0;
					next_q.load_req = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign active = q.active;
	assign dead = q.dead;
	assign load_req = q.load_req;
	assign wake_ack = q.wake_ack;

	gate_wait_a: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(q.st == ST_GATE && run && !gate_hit) |=> (q.st == ST_GATE && !active))
		else $error("context left start gate without a timer match");

	run_start_a: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(q.st == ST_IDLE && run && !gate_en) |=> (active && load_req))
		else $error("run did not start program load");

	wake_load_a: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(q.st == ST_SLEEP && run && wake) |=> (active && wake_ack ##1 !wake_ack))
		else $error("wake did not resume the context");

	err_dead_a: assert property (
		@(posedge mclk) disable iff (!reset_n)
		(q.st == ST_BUSY && run && evt_err)
		|=> (dead && !active) ##1 (!active && (dead || !$past(run))))
		else $error("error did not leave the context dead");
endmodule

`default_nettype wire

// ==== design/dcp_ctx_ctrl.sv ====
// Control and program pointer registers for nine DMA contexts.
// Assumes register port, event bus and cycle timer share mclk.
//
// Behaviour
// - Error leaves failing descriptor address in pointer.
// - Completion leaves last address, count reads zero.
// - Pointer holds address 31:4, count 3:0.
// - Four separate transmit control registers.
// - Transmit start gate clears once active.
// - Gated start waits for cycle timer match.
// - Writing run one starts the controller.
// - Writing wake one resumes a waiting controller.
// - Dead on fatal error, active while processing.
// - Result code reported in bits 4:0.
// - Multichannel ignores the single channel id.
// - Receive start gate clears once active.
// - Split storage clears multichannel and fill.
// - Bit 31 selects fill or per-packet storage.
// - Bit 30 clear strips header and trailer.
// - Multichannel accepts masked channels, else one.
// - Receive speed reported in bits 7:5.
// - Wake clears wake, sets active, reloads.
// - Not ready clears active; error sets dead.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dcp_params.svh"

module dcp_ctx_ctrl
	import dcp_pkg::*;
(
	input wire logic mclk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic [7:0] addr, // Register byte address
	input wire logic [31:0] wr_data, // Register write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [31:0] rd_data, // Read data, cycle after strobe
	input wire logic [14:0] cycle_time, // Cycle timer seconds and count
	input wire logic [59:0] rx_start_time, // Receive start times, 15 bits each
	input wire logic evt_valid, // Program event strobe
	input wire logic [3:0] evt_ctx, // Event context number
	input wire logic [1:0] evt_kind, // Done, error or wait
	input wire logic [4:0] evt_code, // Event result code
	input wire logic [27:0] evt_addr, // Descriptor address of event
	input wire logic [2:0] evt_spd, // Receive speed of event
	output logic launch_valid, // Program fetch request, pulse
	output logic [3:0] launch_ctx, // Fetch context number
	output logic [27:0] launch_addr, // Fetch descriptor address
	output logic [3:0] launch_cnt, // Fetch descriptor count
	input wire logic rx_pkt_valid, // Received iso packet strobe
	input wire logic [5:0] rx_pkt_channel, // Received packet channel
	input wire logic [23:0] single_channel_id, // Receive channels, 6 bits each
	input wire logic [63:0] channel_enable_mask, // Multichannel enables
	output logic [3:0] rx_accept, // Packet taken per receive context
	output logic [3:0] rx_fill_mode, // Fill storage per receive context
	output logic [3:0] rx_strip_header // Strip header per receive context
);
	dcp_top_t q;
	dcp_top_t next_q;
	logic [`DCP_NCTX-1:0] eng_active;
	logic [`DCP_NCTX-1:0] eng_dead;
	logic [`DCP_NCTX-1:0] eng_req;
	logic [`DCP_NCTX-1:0] eng_wack;
	logic [`DCP_NCTX-1:0] gate_hit;
	logic [`DCP_NCTX-1:0] grant;
	logic [`DCP_NCTX-1:0] ev_done;
	logic [`DCP_NCTX-1:0] ev_err;
	logic [`DCP_NCTX-1:0] ev_wait;
	logic [3:0] win;
	logic [3:0] wctx;
	logic wsel;
	logic wok;

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic logic is_tx(input logic [3:0] c);
		return c >= `DCP_TX0 && c < `DCP_RX0;
	endfunction

	function automatic logic is_rx(input logic [3:0] c);
		return c >= `DCP_RX0 && c < 4'(`DCP_NCTX);
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'h0 && !a[`DCP_TOP_BIT]
			&& a[`DCP_CTX_HI:`DCP_CTX_LO] < 4'(`DCP_NCTX);
	endfunction

	function automatic logic [3:0] first_req(input logic [`DCP_NCTX-1:0] r);
		logic [3:0] k;
		k = 4'h0;
		for (int i = `DCP_NCTX - 1; i >= 0; i--) begin
			if (r[i]) begin
				k = 4'(i);
			end
		end
		return k;
	endfunction

	// ----------------------------------------------------------------
	// Decode and per-context engines
	// ----------------------------------------------------------------
	assign wctx = addr[`DCP_CTX_HI:`DCP_CTX_LO];
	assign wsel = addr[`DCP_SEL_BIT];
	assign wok = addr_ok(addr);
	assign win = first_req(eng_req);

	for (genvar i = 0; i < `DCP_NCTX; i++) begin : g_ctx
		localparam logic [3:0] CI = 4'(i);
		// Chosen per context, so no start time select leaves its range
		if (i >= `DCP_TX0 && i < `DCP_RX0) begin : g_tx
			assign gate_hit[i] = cycle_time == q.tx_time[i-`DCP_TX0];
		end else if (i >= `DCP_RX0) begin : g_rx
			assign gate_hit[i] = cycle_time == rx_start_time[(i-`DCP_RX0)*15 +: 15];
		end else begin : g_none
			assign gate_hit[i] = 1'b0;
		end
		assign grant[i] = eng_req[i] && win == CI;
		assign ev_done[i] = evt_valid && evt_ctx == CI && evt_kind == EV_DONE;
		assign ev_err[i] = evt_valid && evt_ctx == CI && evt_kind == EV_ERR;
		assign ev_wait[i] = evt_valid && evt_ctx == CI && evt_kind == EV_WAIT;

		dcp_ctx_engine u_eng (
			.mclk(mclk),
			.reset_n(reset_n),
			.run(q.run[i]),
			.wake(q.wake[i]),
			.gate_en(q.gate_en[i]),
			.gate_hit(gate_hit[i]),
			.grant(grant[i]),
			.evt_done(ev_done[i]),
			.evt_err(ev_err[i]),
			.evt_wait(ev_wait[i]),
			.active(eng_active[i]),
			.dead(eng_dead[i]),
			.load_req(eng_req[i]),
			.wake_ack(eng_wack[i])
		);
	end

	// ----------------------------------------------------------------
	// Register read view
	// ----------------------------------------------------------------
	function automatic logic [31:0] rd_word(input logic [3:0] c, input logic s);
		logic [31:0] w;
		logic [1:0] k;
		w = 32'h0;
		k = 2'h0;
		if (s) begin
			w[`DCP_ADDR_HI:`DCP_ADDR_LO] = q.addr[c];
			w[`DCP_CNT_HI:`DCP_CNT_LO] = q.cnt[c];
		end else begin
			w[`DCP_RUN] = q.run[c];
			w[`DCP_WAKE] = q.wake[c];
			w[`DCP_DEAD] = eng_dead[c];
			w[`DCP_ACT] = eng_active[c];
			w[`DCP_CODE_HI:`DCP_CODE_LO] = q.code[c];
			if (is_tx(c)) begin
				k = 2'(c - `DCP_TX0);
				w[`DCP_TX_GATE] = q.gate_en[c];
				w[`DCP_TX_TIME_HI:`DCP_TX_TIME_LO] = q.tx_time[k];
			end else begin
				w[`DCP_SPD_HI:`DCP_SPD_LO] = q.spd[c];
			end
			if (is_rx(c)) begin
				k = 2'(c - `DCP_RX0);
				w[`DCP_RX_FILL] = q.fill[k];
				w[`DCP_RX_KEEP] = q.keep[k];
				w[`DCP_RX_GATE] = q.gate_en[c];
				w[`DCP_RX_MANY] = q.many[k];
				w[`DCP_RX_SPLIT] = q.split[k];
			end
		end
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] c;
		logic [1:0] k;
		logic ch_ok;
		c = wctx;
		k = 2'h0;
		ch_ok = 1'b0;
		next_q = q;

		// Wake consumed by its engine; a new write below still sets it
		for (int i = 0; i < `DCP_NCTX; i++) begin
			if (eng_wack[i]) begin
				next_q.wake[i] = 1'b0;
			end
			if (evt_valid && evt_ctx == 4'(i)) begin
				next_q.code[i] = evt_code;
				if (evt_kind == EV_ERR || evt_kind == EV_DONE) begin
					next_q.addr[i] = evt_addr;
				end
				if (evt_kind == EV_DONE) begin
					next_q.cnt[i] = `DCP_CNT_DONE;
				end
				if (!is_tx(4'(i))) begin
					next_q.spd[i] = evt_spd;
				end
			end
		end

		if (wr_en && wok) begin
			if (wsel) begin
				if (!q.run[c] && !eng_active[c]) begin
					next_q.addr[c] = wr_data[`DCP_ADDR_HI:`DCP_ADDR_LO];
					next_q.cnt[c] = wr_data[`DCP_CNT_HI:`DCP_CNT_LO];
				end
			end else begin
				next_q.run[c] = wr_data[`DCP_RUN];
				if (wr_data[`DCP_WAKE]) begin
					next_q.wake[c] = 1'b1;
				end
				if (is_tx(c)) begin
					k = 2'(c - `DCP_TX0);
					next_q.gate_en[c] = wr_data[`DCP_TX_GATE];
					next_q.tx_time[k] = wr_data[`DCP_TX_TIME_HI:`DCP_TX_TIME_LO];
				end
				if (is_rx(c) && !q.run[c] && !eng_active[c]) begin
					k = 2'(c - `DCP_RX0);
					next_q.fill[k] = wr_data[`DCP_RX_FILL];
					next_q.keep[k] = wr_data[`DCP_RX_KEEP];
					next_q.gate_en[c] = wr_data[`DCP_RX_GATE];
					next_q.many[k] = wr_data[`DCP_RX_MANY];
					next_q.split[k] = wr_data[`DCP_RX_SPLIT];
					if (wr_data[`DCP_RX_SPLIT]) begin
						next_q.many[k] = 1'b0;
						next_q.fill[k] = 1'b0;
					end
				end
			end
		end

		// Start gate drops once the context is processing
		for (int i = 0; i < `DCP_NCTX; i++) begin
			if (eng_active[i]) begin
				next_q.gate_en[i] = 1'b0;
			end
		end

		next_q.rd_data = (rd_en && addr_ok(addr)) ? rd_word(wctx, wsel) : 32'h0;

		next_q.launch_valid = |eng_req;
		next_q.launch_ctx = win;
		next_q.launch_addr = q.addr[win];
		next_q.launch_cnt = q.cnt[win];

		// Multichannel mode looks only at the mask
		for (int j = 0; j < `DCP_NRX; j++) begin
			c = `DCP_RX0 + 4'(j);
			ch_ok = q.many[j] ? channel_enable_mask[rx_pkt_channel]
				: rx_pkt_channel == single_channel_id[j*6 +: 6];
			next_q.rx_accept[j] = rx_pkt_valid && q.run[c] && eng_active[c] && ch_ok;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign rd_data = q.rd_data;
	assign launch_valid = q.launch_valid;
	assign launch_ctx = q.launch_ctx;
	assign launch_addr = q.launch_addr;
	assign launch_cnt = q.launch_cnt;
	assign rx_accept = q.rx_accept;
	assign rx_fill_mode = q.fill;
	assign rx_strip_header = ~q.keep;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	ptr_hold_a: assert property (
		(wr_en && wok && wsel && (q.run[wctx] || eng_active[wctx]) && !evt_valid)
		|=> q.addr[$past(wctx)] == $past(q.addr[wctx]))
		else $error("busy pointer write changed the address");

	err_addr_a: assert property (
		(evt_valid && evt_kind == EV_ERR) |=> q.addr[$past(evt_ctx)] == $past(evt_addr))
		else $error("error did not keep failing descriptor address");

	done_count_a: assert property (
		(evt_valid && evt_kind == EV_DONE && !wr_en)
		|=> q.cnt[$past(evt_ctx)] == `DCP_CNT_DONE)
		else $error("completion did not zero the count");

	result_code_a: assert property (
		evt_valid |=> q.code[$past(evt_ctx)] == $past(evt_code))
		else $error("result code not stored");

	tx_gate_clear_a: assert property (
		(eng_active[`DCP_TX0] && !(wr_en && wctx == `DCP_TX0))
		|=> !q.gate_en[`DCP_TX0])
		else $error("transmit start gate kept while active");

	rx_gate_clear_a: assert property (
		eng_active[`DCP_RX0] |=> !q.gate_en[`DCP_RX0])
		else $error("receive start gate kept while active");

	split_clears_a: assert property (
		(wr_en && wok && !wsel && is_rx(wctx) && !q.run[wctx] && !eng_active[wctx]
			&& wr_data[`DCP_RX_SPLIT])
		|=> (q.many == ($past(q.many) & ~(4'h1 << $past(2'(wctx - `DCP_RX0))))))
		else $error("split storage did not clear multichannel");

	many_accept_a: assert property (
		(rx_pkt_valid && q.many[0] && q.run[`DCP_RX0] && eng_active[`DCP_RX0])
		|=> rx_accept[0] == $past(channel_enable_mask[rx_pkt_channel]))
		else $error("multichannel accept ignored the mask");

	read_pulse_a: assert property (
		!rd_en |=> rd_data == 32'h0)
		else $error("read data stood outside its cycle");
endmodule

`default_nettype wire

// ==== test/dcp_host_model.sv ====
// Host memory and loader model answering program fetch requests.
// Assumes the bench sets the outcome before each fetch is launched.
`timescale 1ns/1ns
`default_nettype none

module dcp_host_model (
	input wire logic mclk, // Core clock
	input wire logic reset_n, // Async reset
	input wire logic launch_valid, // Fetch request
	input wire logic [3:0] launch_ctx, // Fetch context
	input wire logic [1:0] cmd_kind, // Outcome to report
	input wire logic [4:0] cmd_code, // Code to report
	input wire logic [27:0] cmd_addr, // Address to report
	input wire logic [2:0] cmd_spd, // Speed to report
	input wire logic [7:0] cmd_dly, // Cycles from fetch to outcome
	output logic evt_valid, // Outcome strobe
	output logic [3:0] evt_ctx, // Outcome context
	output logic [1:0] evt_kind, // Outcome kind
	output logic [4:0] evt_code, // Outcome code
	output logic [27:0] evt_addr, // Outcome address
	output logic [2:0] evt_spd // Outcome speed
);
	logic [7:0] cnt;
	logic [3:0] ctx;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 8'h00;
			ctx <= 4'h0;
			evt_valid <= 1'b0;
			{evt_ctx, evt_kind, evt_code, evt_addr, evt_spd} <= '0;
		end else begin
			evt_valid <= 1'b0;
			if (launch_valid) begin
				cnt <= cmd_dly;
				ctx <= launch_ctx;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
			if (cnt == 8'h01 && !launch_valid) begin
				evt_valid <= 1'b1;
				evt_ctx <= ctx;
				evt_kind <= cmd_kind;
				evt_code <= cmd_code;
				evt_addr <= cmd_addr;
				evt_spd <= cmd_spd;
			end else begin
				// Idle lines toggle so stale values never look valid
				{evt_ctx, evt_kind, evt_code, evt_addr, evt_spd} <=
					~{evt_ctx, evt_kind, evt_code, evt_addr, evt_spd};
			end
		end
	end
endmodule

`default_nettype wire

// ==== test/tb_dcp_ctx_ctrl.sv ====
// Self-checking bench for the DMA context control registers.
// Assumes dcp_host_model answers every fetch as last commanded.
`timescale 1ns/1ns
`default_nettype none

module tb_dcp_ctx_ctrl;
	import dcp_pkg::*;
	logic mclk, reset_n, wr_en, rd_en, rx_pkt_valid, launch_valid, evt_valid;
	logic [7:0] addr, cmd_dly;
	logic [31:0] wr_data, rd_data, v;
	logic [14:0] cycle_time, t, d;
	logic [3:0] launch_ctx, evt_ctx, launch_cnt, rx_accept, rx_fill_mode, rx_strip_header;
	logic [27:0] launch_addr, evt_addr, cmd_addr;
	logic [1:0] evt_kind, cmd_kind;
	logic [4:0] evt_code, cmd_code;
	logic [2:0] evt_spd, cmd_spd;
	logic [5:0] rx_pkt_channel;
	logic [7:0] pa [5] = '{8'h04, 8'h0c, 8'h14, 8'h2c, 8'h34};
	logic [31:0] pd [5] = '{32'h0000_1231, 32'h0000_2342, 32'h0000_3458,
		32'h0000_4561, 32'h0000_5678};
	int checks = 0;
	int fail_count = 0;

	dcp_ctx_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cycle_time(cycle_time),
		.rx_start_time(60'h0), .evt_valid(evt_valid), .evt_ctx(evt_ctx),
		.evt_kind(evt_kind), .evt_code(evt_code), .evt_addr(evt_addr), .evt_spd(evt_spd),
		.launch_valid(launch_valid), .launch_ctx(launch_ctx), .launch_addr(launch_addr),
		.launch_cnt(launch_cnt), .rx_pkt_valid(rx_pkt_valid),
		.rx_pkt_channel(rx_pkt_channel), .single_channel_id(24'h000003),
		.channel_enable_mask(64'h200), .rx_accept(rx_accept),
		.rx_fill_mode(rx_fill_mode), .rx_strip_header(rx_strip_header));

	dcp_host_model u_host (.mclk(mclk), .reset_n(reset_n), .launch_valid(launch_valid),
		.launch_ctx(launch_ctx), .cmd_kind(cmd_kind), .cmd_code(cmd_code),
		.cmd_addr(cmd_addr), .cmd_spd(cmd_spd), .cmd_dly(cmd_dly),
		.evt_valid(evt_valid), .evt_ctx(evt_ctx), .evt_kind(evt_kind),
		.evt_code(evt_code), .evt_addr(evt_addr), .evt_spd(evt_spd));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) cycle_time <= cycle_time + 15'h0001;

	// ---------------------------------------------------------------
	// Bus and check tasks
	// ---------------------------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge mclk);
		addr <= a;
		wr_data <= dat;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 q = rd_data;
	endtask

	task automatic waitfor(input bit lv);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (!(lv ? launch_valid === 1'b1 : evt_valid === 1'b1) && n < 200);
		if (n >= 200) begin
			fail_count++;
			$display("[ERR] wait expected handshake seen none");
			complete_run();
		end
	endtask

	task automatic wl(input logic [3:0] c, input logic [31:0] p);
		waitfor(1'b1);
		chk("launch ctx", {28'h0, launch_ctx}, {28'h0, c});
		chk("launch ptr", {launch_addr, launch_cnt}, p);
	endtask

	task automatic cmd(input logic [1:0] k, input logic [4:0] c, input logic [27:0] a,
		input logic [2:0] s, input logic [7:0] dl);
		cmd_kind = k;
		cmd_code = c;
		cmd_addr = a;
		cmd_spd = s;
		cmd_dly = dl;
	endtask

	task automatic pk(input logic [5:0] ch, input logic [3:0] e);
		@(posedge mclk);
		rx_pkt_channel <= ch;
		rx_pkt_valid <= 1'b1;
		@(posedge mclk);
		rx_pkt_valid <= 1'b0;
		#1 chk("rx accept", {28'h0, rx_accept}, {28'h0, e});
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{addr, wr_data, wr_en, rd_en, rx_pkt_valid, rx_pkt_channel} = '0;
		cycle_time = 15'h0000;
		reset_n = 1'b0;
		cmd(2'h1, 5'h00, 28'h0, 3'h0, 8'h04);
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd(8'(8 * i), v);
			chk("reset flags", v & 32'h0000_8c00, 32'h0);
		end
		rd(8'h48, v);
		chk("unmapped", v, 32'h0);
		rd(8'h80, v);
		chk("unmapped", v, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 5; i++) begin
			wr(pa[i], pd[i]);
			rd(pa[i], v);
			chk("pointer", v, pd[i]);
		end
		$display("test pointer done");
		cmd(2'h1, 5'h11, 28'h00abcd0, 3'h0, 8'h14);
		wr(8'h08, 32'h0000_8000);
		wl(4'h1, 32'h0000_2342);
		rd(8'h08, v);
		chk("tx busy", v, 32'h0000_8400);
		waitfor(1'b0);
		rd(8'h08, v);
		chk("tx done", v, 32'h0000_8011);
		rd(8'h0c, v);
		chk("ptr done", v, 32'h00ab_cd00);
		wr(8'h0c, 32'h5555_5552);
		rd(8'h0c, v);
		chk("ptr locked", v, 32'h00ab_cd00);
		cmd(2'h2, 5'h06, 28'h0111110, 3'h0, 8'h14);
		wr(8'h08, 32'h0000_9000);
		wl(4'h1, 32'h00ab_cd00);
		rd(8'h08, v);
		chk("tx woken", v, 32'h0000_8411);
		waitfor(1'b0);
		rd(8'h08, v);
		chk("tx dead", v, 32'h0000_8806);
		rd(8'h0c, v);
		chk("ptr error", v, 32'h0111_1100);
		$display("test tx run done");
		t = cycle_time + 15'd40;
		cmd(2'h3, 5'h0a, 28'h0, 3'h0, 8'h04);
		wr(8'h10, {1'b1, t, 16'h8000});
		wl(4'h2, 32'h0000_3458);
		d = cycle_time - t;
		chk("gate time", {31'h0, d >= 15'd1 && d <= 15'd4}, 32'h1);
		waitfor(1'b0);
		rd(8'h10, v);
		chk("gate clear", v, {1'b0, t, 16'h800a});
		$display("test gate done");
		wr(8'h28, 32'h8000_0000);
		repeat (2) @(posedge mclk);
		#1 chk("fill", {28'h0, rx_fill_mode}, 32'h1);
		chk("strip", {28'h0, rx_strip_header}, 32'hf);
		wr(8'h28, 32'h9800_0000);
		rd(8'h28, v);
		chk("split", v & 32'hf800_0000, 32'h0800_0000);
		cmd(2'h1, 5'h11, 28'h0222220, 3'h2, 8'h1e);
		wr(8'h28, 32'hd000_8000);
		wl(4'h5, 32'h0000_4561);
		pk(6'd9, 4'h1);
		pk(6'd3, 4'h0);
		chk("keep", {28'h0, rx_strip_header}, 32'he);
		waitfor(1'b0);
		rd(8'h28, v);
		chk("rx done", v, 32'hd000_8051);
		rd(8'h2c, v);
		chk("rx ptr", v, 32'h0222_2200);
		$display("test rx done");
		complete_run();
	end
endmodule

`default_nettype wire
